//--- pkg/lpis_if.sv
// two-wire link between the master end and the led driver end
interface lpis_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // open-drain wires with pull-ups
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : lpis_if

//--- pkg/lpis_pkg.sv
// shared constants and types for the led pwm serial link
package lpis_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // channel pwm: about 97 kHz over 256 steps
  localparam int unsigned CH_PWM_HZ = 97_000;
  localparam int unsigned CH_TICK_CYC = CLK_HZ / (CH_PWM_HZ * 256) < 1 ? 1 : CLK_HZ / (CH_PWM_HZ * 256);
  // group dimming: about 190 Hz over 256 steps
  localparam int unsigned DIM_HZ = 190;
  localparam int unsigned DIM_TICK_CYC = CLK_HZ / (DIM_HZ * 256);
  // blinking: period (code+1) x 1/24 s, code 255 gives 10.67 s
  localparam int unsigned BLINK_HZ = 24;
  localparam int unsigned BLINK_TICK_CYC = CLK_HZ / (BLINK_HZ * 256);
  localparam int unsigned NUM_CH = 24;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_ON = 2'h1;
  localparam logic [1:0] MODE_IND = 2'h2;
  localparam logic [1:0] MODE_GRP = 2'h3;
  localparam int unsigned BYTE_BITS = 8;
  localparam int unsigned FIFO_DEPTH = 8;
  // host clock divider: half period of scl in clk cycles (160 ns period)
  localparam int unsigned SCL_HALF_CYC = 8;
  typedef enum logic [2:0] {
    LPIS_S_IDLE = 3'h0,
    LPIS_S_BIT = 3'h1,
    LPIS_S_ACK = 3'h2,
    LPIS_S_WAIT = 3'h3
  } lpis_slv_st_t;
  typedef enum logic [2:0] {
    LPIS_M_IDLE = 3'h0,
    LPIS_M_START = 3'h1,
    LPIS_M_LOW = 3'h2,
    LPIS_M_HIGH = 3'h3,
    LPIS_M_STOP0 = 3'h4,
    LPIS_M_STOP1 = 3'h5
  } lpis_mst_st_t;
endpackage : lpis_pkg

//--- rtl/lpis_fifo.sv
// small valid/ready fifo
module lpis_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } lpis_fifo_st_t;
  lpis_fifo_st_t st_reg;
  lpis_fifo_st_t st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic do_wr;
  logic do_rd;
  // full and empty from pointer difference
  assign out_valid = st_reg.wp != st_reg.rp;
  assign in_ready = (st_reg.wp - st_reg.rp) != (AW+1)'(DEPTH);
  assign out_data = mem[st_reg.rp[AW-1:0]];
  assign do_wr = in_valid & in_ready;
  assign do_rd = out_valid & out_ready;
  // pointer update
  always_comb begin
    st_next = st_reg;
    if (do_wr) begin
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (do_rd) begin
      st_next.rp = st_reg.rp + 1'b1;
    end
  end
  // state and storage
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
    if (do_wr) begin
      mem[st_reg.wp[AW-1:0]] <= in_data;
    end
  end
endmodule : lpis_fifo

//--- rtl/lpis_master.sv
// master end: drives scl by divider and frames byte transfers
module lpis_master (
  input wire logic clk,
  input wire logic resetn,
  lpis_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_read,
  input wire logic cmd_last,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic ack_seen
);
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    lpis_pkg::lpis_mst_st_t st;
    logic [7:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rd;
    logic last;
    logic scl_o;
    logic sda_o;
    logic ready;
    logic [7:0] rdat;
    logic rvalid;
    logic ack;
  } lpis_mst_t;
  lpis_mst_t m_reg;
  lpis_mst_t m_next;
  logic half_done;
  logic idle_bus;
  assign half_done = m_reg.div == 8'(lpis_pkg::SCL_HALF_CYC - 1);
  assign idle_bus = m_reg.scl_sy[1] & m_reg.sda_sy[1];
  assign bus.scl_o = m_reg.scl_o;
  assign bus.scl_oe = ~m_reg.scl_o;
  assign bus.sda_m_o = m_reg.sda_o;
  assign bus.sda_m_oe = ~m_reg.sda_o;
  assign cmd_ready = m_reg.ready;
  assign rd_data = m_reg.rdat;
  assign rd_valid = m_reg.rvalid;
  assign ack_seen = m_reg.ack;
  // next state
  always_comb begin
    m_next = m_reg;
    m_next.scl_sy = {m_reg.scl_sy[0], bus.scl};
    m_next.sda_sy = {m_reg.sda_sy[0], bus.sda};
    m_next.rvalid = 1'b0;
    m_next.ready = 1'b0;
    m_next.div = half_done ? 8'h0 : m_reg.div + 8'h1;
    case (m_reg.st)
      lpis_pkg::LPIS_M_IDLE: begin
        m_next.div = 8'h0;
        m_next.scl_o = 1'b1;
        m_next.sda_o = 1'b1;
        if (cmd_valid && idle_bus && !m_reg.ready) begin
          m_next.st = lpis_pkg::LPIS_M_START;
          m_next.sda_o = 1'b0;
          m_next.rd = cmd_read;
          m_next.last = cmd_last;
          m_next.sh = cmd_read ? 8'hff : cmd_data;
          m_next.bitn = 4'h0;
          m_next.ready = 1'b1;
        end
      end
      lpis_pkg::LPIS_M_START: begin
        if (half_done) begin
          m_next.st = lpis_pkg::LPIS_M_LOW;
          m_next.scl_o = 1'b0;
        end
      end
      lpis_pkg::LPIS_M_LOW: begin
        if (m_reg.div == 8'h1) begin
          // data changes only while scl is low
          if (m_reg.bitn == 4'(lpis_pkg::BYTE_BITS)) begin
            m_next.sda_o = m_reg.rd ? m_reg.last : 1'b1;
          end else begin
            m_next.sda_o = m_reg.rd ? 1'b1 : m_reg.sh[7];
          end
        end
        if (half_done) begin
          m_next.st = lpis_pkg::LPIS_M_HIGH;
          m_next.scl_o = 1'b1;
        end
      end
      lpis_pkg::LPIS_M_HIGH: begin
        if (half_done) begin
          m_next.scl_o = 1'b0;
          m_next.st = lpis_pkg::LPIS_M_LOW;
          if (m_reg.bitn == 4'(lpis_pkg::BYTE_BITS)) begin
            m_next.ack = ~m_reg.sda_sy[1];
            m_next.bitn = 4'h0;
            if (m_reg.last || (!m_reg.rd && m_reg.sda_sy[1])) begin
              m_next.st = lpis_pkg::LPIS_M_STOP0;
            end else begin
              m_next.sh = cmd_data;
              m_next.last = cmd_last;
              m_next.ready = 1'b1;
            end
          end else begin
            m_next.bitn = m_reg.bitn + 4'h1;
            m_next.sh = {m_reg.sh[6:0], m_reg.sda_sy[1]};
            if (m_reg.bitn == 4'h7 && m_reg.rd) begin
              m_next.rdat = {m_reg.sh[6:0], m_reg.sda_sy[1]};
              m_next.rvalid = 1'b1;
            end
          end
        end
      end
      lpis_pkg::LPIS_M_STOP0: begin
        if (m_reg.div == 8'h1) begin
          m_next.sda_o = 1'b0;
        end
        if (half_done) begin
          m_next.scl_o = 1'b1;
          m_next.st = lpis_pkg::LPIS_M_STOP1;
        end
      end
      default: begin
        if (half_done) begin
          m_next.sda_o = 1'b1;
          m_next.st = lpis_pkg::LPIS_M_IDLE;
        end
      end
    endcase
  end
  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      m_reg <= '0;
      m_reg.scl_sy <= 2'h3;
      m_reg.sda_sy <= 2'h3;
      m_reg.scl_o <= 1'b1;
      m_reg.sda_o <= 1'b1;
      m_reg.st <= lpis_pkg::LPIS_M_IDLE;
    end else begin
      m_reg <= m_next;
    end
  end
endmodule : lpis_master

//--- rtl/lpis_slave.sv
// led driver end: serial slave plus brightness engine
// Summary of operation
// - per-channel 97 kHz pwm, 8-bit duty
// - group dimming, 190 Hz, 8-bit duty
// - group blinking, programmable period and duty
// - only dimming or blinking, never both
// - both lines released while idle
// - sda fall with scl high is start
// - sda rise with scl high is stop
// - one bit per scl pulse, stable high
// - master starts only on idle bus
// - ninth pulse acknowledges, transmitter releases sda
// - slave acknowledges each received byte the fifo accepts, nack when full
// - master acknowledges read bytes except last
// - acknowledger holds sda low through high
// - unacknowledged last byte, slave releases sda
// - no byte count limit per transfer
// - mode 00 off 01 on 10 ind 11 grp
// - output enable high floats every led
module lpis_slave #(
  parameter int NUM_CH = lpis_pkg::NUM_CH
) (
  input wire logic clk,
  input wire logic resetn,
  lpis_if.slave bus,
  input wire logic read_mode,
  input wire logic [7:0] tx_data,
  input wire logic [NUM_CH*2-1:0] channel_output_mode,
  input wire logic [NUM_CH*8-1:0] channel_duty_cycle,
  input wire logic [7:0] group_duty_cycle,
  input wire logic [7:0] group_freq,
  input wire logic blink_sel,
  input wire logic output_enable_n,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic busy,
  output logic [NUM_CH-1:0] led_o,
  output logic [NUM_CH-1:0] led_oe
);
  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    logic scl_d;
    logic sda_d;
    logic oe_n_s0;
    logic oe_n_s1;
    lpis_pkg::lpis_slv_st_t st;
    logic [3:0] bitn;
    logic [7:0] shreg;
    logic rd;
    logic sda_o;
    logic sda_oe;
    logic [7:0] wbyte;
    logic wvalid;
    logic busy;
    logic [7:0] ch_pre;
    logic [7:0] ch_cnt;
    logic [15:0] g_pre;
    logic [7:0] g_cnt;
    logic [7:0] g_div;
    logic g_on;
    logic [NUM_CH-1:0] led_o;
    logic [NUM_CH-1:0] led_oe;
  } lpis_slv_t;
  lpis_slv_t s_reg;
  lpis_slv_t s_next;
  logic fifo_in_ready;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [15:0] g_tick_cyc;
  logic ind_on;
  logic [1:0] md;
  // synchronised line views
  assign scl_s = s_reg.scl_sy[1];
  assign sda_s = s_reg.sda_sy[1];
  assign scl_rise = scl_s & ~s_reg.scl_d;
  assign scl_fall = ~scl_s & s_reg.scl_d;
  assign start_ev = scl_s & s_reg.scl_d & s_reg.sda_d & ~sda_s;
  assign stop_ev = scl_s & s_reg.scl_d & ~s_reg.sda_d & sda_s;
  assign g_tick_cyc = blink_sel ? 16'(lpis_pkg::BLINK_TICK_CYC) : 16'(lpis_pkg::DIM_TICK_CYC);
  assign bus.sda_s_o = s_reg.sda_o;
  assign bus.sda_s_oe = s_reg.sda_oe;
  assign busy = s_reg.busy;
  assign led_o = s_reg.led_o;
  assign led_oe = s_reg.led_oe;
  // received bytes queue; a full queue shows as nack
  lpis_fifo #(
    .WIDTH(8),
    .DEPTH(lpis_pkg::FIFO_DEPTH)
  ) lpis_fifo_i (
    .clk(clk),
    .resetn(resetn),
    .in_valid(s_reg.wvalid),
    .in_ready(fifo_in_ready),
    .in_data(s_reg.wbyte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );
  // next state
  always_comb begin
    s_next = s_reg;
    ind_on = 1'b0;
    md = 2'h0;
    s_next.scl_sy = {s_reg.scl_sy[0], bus.scl};
    s_next.sda_sy = {s_reg.sda_sy[0], bus.sda};
    s_next.scl_d = scl_s;
    s_next.sda_d = sda_s;
    s_next.oe_n_s0 = output_enable_n;
    s_next.oe_n_s1 = s_reg.oe_n_s0;
    s_next.wvalid = 1'b0;
    // byte engine
    case (s_reg.st)
      lpis_pkg::LPIS_S_IDLE: begin
        s_next.sda_oe = 1'b0;
      end
      lpis_pkg::LPIS_S_BIT: begin
        if (scl_rise) begin
          // a transmitting slave shifts on the fall only, so one bit per pulse
          if (!s_reg.rd) begin
            s_next.shreg = {s_reg.shreg[6:0], sda_s};
          end
          s_next.bitn = s_reg.bitn + 4'h1;
        end else if (scl_fall && s_reg.bitn == 4'(lpis_pkg::BYTE_BITS)) begin
          s_next.st = lpis_pkg::LPIS_S_ACK;
          s_next.bitn = 4'h0;
          if (s_reg.rd) begin
            s_next.sda_oe = 1'b0;
          end else begin
            s_next.sda_o = 1'b0;
            s_next.sda_oe = fifo_in_ready;
            s_next.wbyte = s_reg.shreg;
            s_next.wvalid = fifo_in_ready;
          end
        end else if (scl_fall && s_reg.rd) begin
          s_next.sda_o = 1'b0;
          s_next.sda_oe = ~s_reg.shreg[7];
          s_next.shreg = {s_reg.shreg[6:0], 1'b1};
        end
      end
      lpis_pkg::LPIS_S_ACK: begin
        if (scl_rise && s_reg.rd && sda_s) begin
          s_next.st = lpis_pkg::LPIS_S_WAIT;
        end else if (scl_fall) begin
          s_next.st = lpis_pkg::LPIS_S_BIT;
          s_next.sda_oe = 1'b0;
          if (s_reg.rd) begin
            s_next.sda_o = 1'b0;
            s_next.sda_oe = ~tx_data[7];
            s_next.shreg = {tx_data[6:0], 1'b1};
          end
        end
      end
      default: begin
        s_next.sda_oe = 1'b0;
      end
    endcase
    if (start_ev) begin
      s_next.st = lpis_pkg::LPIS_S_BIT;
      s_next.bitn = 4'h0;
      s_next.sda_oe = 1'b0;
      s_next.busy = 1'b1;
      s_next.rd = read_mode;
      s_next.shreg = '0;
      // first bit goes out on the first scl fall, never while scl is high
      if (read_mode) begin
        s_next.shreg = tx_data;
      end
    end else if (stop_ev) begin
      s_next.st = lpis_pkg::LPIS_S_IDLE;
      s_next.sda_oe = 1'b0;
      s_next.busy = 1'b0;
    end
    // channel pwm timebase
    if (s_reg.ch_pre >= 8'(lpis_pkg::CH_TICK_CYC - 1)) begin
      s_next.ch_pre = 8'h0;
      s_next.ch_cnt = s_reg.ch_cnt + 8'h1;
    end else begin
      s_next.ch_pre = s_reg.ch_pre + 8'h1;
    end
    // group timebase: dimming fixed, blinking divided by group_freq+1
    if (s_reg.g_pre >= g_tick_cyc - 16'h1) begin
      s_next.g_pre = 16'h0;
      if (!blink_sel || s_reg.g_div >= group_freq) begin
        s_next.g_div = 8'h0;
        s_next.g_cnt = s_reg.g_cnt + 8'h1;
      end else begin
        s_next.g_div = s_reg.g_div + 8'h1;
      end
    end else begin
      s_next.g_pre = s_reg.g_pre + 16'h1;
    end
    s_next.g_on = s_reg.g_cnt < group_duty_cycle;
    // led outputs, open drain: driven low means lit
    for (int i = 0; i < NUM_CH; i++) begin
      md = channel_output_mode[i*2 +: 2];
      ind_on = s_reg.ch_cnt < channel_duty_cycle[i*8 +: 8];
      s_next.led_o[i] = 1'b0;
      case (md)
        lpis_pkg::MODE_ON: s_next.led_oe[i] = 1'b1;
        lpis_pkg::MODE_IND: s_next.led_oe[i] = ind_on;
        lpis_pkg::MODE_GRP: s_next.led_oe[i] = ind_on & s_reg.g_on;
        default: s_next.led_oe[i] = 1'b0;
      endcase
      if (s_reg.oe_n_s1) begin
        s_next.led_oe[i] = 1'b0;
      end
    end
  end
  // state register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_reg <= '0;
      s_reg.scl_sy <= 2'h3;
      s_reg.sda_sy <= 2'h3;
      s_reg.scl_d <= 1'b1;
      s_reg.sda_d <= 1'b1;
      s_reg.oe_n_s0 <= 1'b1;
      s_reg.oe_n_s1 <= 1'b1;
      s_reg.st <= lpis_pkg::LPIS_S_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule : lpis_slave

//--- tb/lpis_bench.sv
// self-checking bench: master end talks to the led driver end over the link
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module lpis_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WIN = 256 * lpis_pkg::CH_TICK_CYC;
  logic clk, resetn, cmd_valid, cmd_read, cmd_last, cmd_ready, rd_valid, ack_seen;
  logic [7:0] cmd_data, rd_data, tx_data, rx_data, group_duty_cycle, group_freq, exp_b, dty;
  logic read_mode, blink_sel, output_enable_n, rx_valid, rx_ready, busy, hold;
  logic [lpis_pkg::NUM_CH*2-1:0] channel_output_mode;
  logic [lpis_pkg::NUM_CH*8-1:0] channel_duty_cycle;
  logic [lpis_pkg::NUM_CH-1:0] led_o, led_oe;
  logic [7:0] wq[$], rq[$];
  int num_errors, check_count, seed, cnt[5];
  lpis_if link();
  lpis_master lpis_master_i (.clk(clk), .resetn(resetn), .bus(link.master), .cmd_valid(cmd_valid),
    .cmd_read(cmd_read), .cmd_last(cmd_last), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .ack_seen(ack_seen));
  lpis_slave lpis_slave_i (.clk(clk), .resetn(resetn), .bus(link.slave), .read_mode(read_mode),
    .tx_data(tx_data), .channel_output_mode(channel_output_mode), .channel_duty_cycle(channel_duty_cycle),
    .group_duty_cycle(group_duty_cycle), .group_freq(group_freq), .blink_sel(blink_sel),
    .output_enable_n(output_enable_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .busy(busy), .led_o(led_o), .led_oe(led_oe));
  lpis_chk lpis_chk_i (.clk(clk), .resetn(resetn), .scl_o(link.scl_o), .scl_oe(link.scl_oe),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe), .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe),
    .scl(link.scl), .sda(link.sda));
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // poll a level after each edge under a bounded count
  task automatic wait_for(ref logic s, input logic lvl);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (s !== lvl && k < 4000);
    if (k >= 4000) num_errors++;
  endtask : wait_for
  // one transfer of n bytes; write bytes below keep are expected at the fifo output
  task automatic xfer(input logic rd, input int n, input int keep);
    for (int i = 0; i < n; i++) begin
      cmd_data = 8'($random(seed));
      cmd_read = rd;
      cmd_last = (i == n - 1);
      cmd_valid = 1'b1;
      if (rd) rq.push_back(tx_data);
      else if (i < keep) wq.push_back(cmd_data);
      wait_for(cmd_ready, 1'b1);
      @(posedge clk);
      #1;
    end
    cmd_valid = 1'b0;
    // a one-byte transfer may not have shown busy yet
    wait_for(busy, 1'b1);
    wait_for(busy, 1'b0);
    repeat (20) @(posedge clk);
    #1;
  endtask : xfer
  // count lit cycles of channels 0..4 over one whole channel pwm period
  task automatic count_window();
    foreach (cnt[j]) cnt[j] = 0;
    repeat (8) @(posedge clk);
    for (int c = 0; c < WIN; c++) begin
      @(posedge clk);
      #1;
      for (int j = 0; j < 5; j++) cnt[j] += int'(led_oe[j]);
    end
  endtask : count_window
  // compare each byte leaving either end against the oldest note
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready === 1'b1) begin
      exp_b = wq.size() ? wq.pop_front() : 8'h00;
      `CHK(rx_data, exp_b)
    end
    if (rd_valid === 1'b1) begin
      exp_b = rq.size() ? rq.pop_front() : 8'h00;
      `CHK(rd_data, exp_b)
    end
  end
  // reader side of the fifo stalls at random, or fully while hold is set
  always @(posedge clk) begin
    #1;
    rx_ready = !hold && ($random(seed) % 4 != 0);
  end
  // watchdog against a hung link
  initial begin
    #400_000;
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    seed = 26424;
    {resetn, cmd_valid, cmd_read, cmd_last, cmd_data, read_mode, tx_data, hold} = '0;
    {channel_output_mode, channel_duty_cycle, group_duty_cycle, blink_sel, output_enable_n} = '0;
    group_freq = 8'h00;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    // writes of one, three and five bytes
    for (int n = 1; n <= 5; n += 2) xfer(1'b0, n, n);
    `CHK(ack_seen, 1'b1)
    // read of three bytes, the last one left unacknowledged
    read_mode = 1'b1;
    tx_data = 8'($random(seed));
    xfer(1'b1, 3, 0);
    `CHK(ack_seen, 1'b0)
    read_mode = 1'b0;
    // reader stalled: eight bytes fill the fifo, the ninth is refused
    hold = 1'b1;
    xfer(1'b0, 9, 8);
    `CHK(ack_seen, 1'b0)
    hold = 1'b0;
    repeat (100) @(posedge clk);
    #1;
    `CHK(wq.size(), 0)
    `CHK(rq.size(), 0)
    // channels 0..4: off, on, individual at zero, individual at dty, combined at dty
    dty = 8'h01 + 8'({$random(seed)} % 255);
    group_freq = 8'($random(seed));
    blink_sel = 1'($random(seed));
    channel_duty_cycle[39:24] = {dty, dty};
    channel_output_mode[9:0] = {lpis_pkg::MODE_GRP, lpis_pkg::MODE_IND, lpis_pkg::MODE_IND,
      lpis_pkg::MODE_ON, lpis_pkg::MODE_OFF};
    // group duty zero keeps the combined channel dark
    count_window();
    `CHK(cnt[0], 0)
    `CHK(cnt[1], WIN)
    `CHK(cnt[2], 0)
    `CHK(cnt[3], int'(dty) * lpis_pkg::CH_TICK_CYC)
    `CHK(cnt[4], 0)
    // group on for its first 255 steps: combined channel follows its own duty
    group_duty_cycle = 8'hff;
    count_window();
    `CHK(cnt[4], int'(dty) * lpis_pkg::CH_TICK_CYC)
    // output enable high floats every led
    output_enable_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK({led_o, led_oe}, 48'h000000000000)
    report_and_stop();
  end
endmodule : lpis_bench

//--- tb/lpis_chk.sv
// concurrent checks on the two-wire link between the master end and the led driver end
module lpis_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // who is pulling the data wire low
  wire logic m_pull = sda_m_oe & ~sda_m_o;
  wire logic s_pull = sda_s_oe & ~sda_s_o;
  // a stop leaves both wires released
  a_stop_idle: assert property (($rose(sda) && scl) |=> (scl && sda)[*2])
    else $error("link not idle after stop");
  // only the master makes a start, the slave stays off the wire
  a_start_master: assert property (($fell(sda) && scl) |-> (m_pull && !s_pull))
    else $error("start not made by the master");
  // a start is followed by the first clock low within the bound
  a_start_clock: assert property (($fell(sda) && scl) |-> ##[1:20] !scl)
    else $error("no clock after start");
  // data only moves in the high phase through the master's start or stop
  a_data_steady: assert property ((scl && $past(scl) && $changed(sda)) |-> ($changed(sda_m_o) || $changed(sda_m_oe)))
    else $error("data moved while clock high");
  // the slave never changes its pull while the clock is high
  a_slave_steady: assert property ((scl && $past(scl)) |-> $stable(s_pull))
    else $error("slave pull changed while clock high");
  // each clock phase lasts at least the divider's half period
  a_scl_high: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  a_scl_low: assert property ($fell(scl) |-> (!scl)[*8])
    else $error("clock low phase too short");
  // while the clock is high, the transmitter is released whenever the other side acknowledges
  a_single_pull: assert property (scl |-> !(m_pull && s_pull))
    else $error("both ends pull the data wire");
endmodule : lpis_chk
